// ==== src/rwc_top.sv ====
// reset and wake control top
// assumes host strobes are synchronous to CLK; wake events come from other logic
`timescale 1ns/1ps
// How it works
// R01 - the reset pin returns every flip-flop of the block to its reset value.
// R02 - the host resets the device at power-up by pin or by the software reset bit.
// R03 - after any reset or wake, host writes are ignored until one read has been seen.
// R04 - with the indicator enabled, a wake event while asleep asserts the wake output.
// R05 - software chooses the active level and push-pull or open-drain drive of that output.
// R06 - a wake event and the indicator never end the power-saving state on their own.
// R07 - power-saving ends only on chip select and write strobe low together; here a software reset also ends it.
// R08 - while asleep any write, whatever address or data, wakes the device.
// R09 - the host aims its wake write at the byte-order test register.
// R10 - the reference clock is 25 MHz, made here as an enable from the core clock.
// R11 - chip select and write strobe are active low; a write is both low together.
// R12 - reset acts at once and is released in step with the clock.
module rwc_top (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic SOFTWARE_RESET_BIT,
	input wire logic CHIP_SELECT_LOW,
	input wire logic WRITE_STROBE_LOW,
	input wire logic READ_STROBE_LOW,
	input wire logic SLEEP_REQ,
	input wire logic WAKE_EVENT,
	input wire logic WAKE_EN,
	input wire logic WAKE_ACTIVE_HIGH,
	input wire logic WAKE_OPEN_DRAIN,
	output logic WAKE_INDICATOR_OUT,
	output logic WAKE_INDICATOR_OE,
	output logic ASLEEP,
	output logic WRITE_ALLOWED,
	output logic WRITE_ACCEPT,
	output logic REF_CLOCK_EN,
	output logic SOFT_RESET_N
);
	// ----------------------------------------
	// reset
	// ----------------------------------------
	logic rst_n;
	logic soft_rst;

	rwc_rst_sync #(
		.STAGES(rwc_pkg::SYNC_STAGES)
	) u_rst_sync (
		.CLK(CLK),
		.ARST_N(ARST_N),
		.rst_n(rst_n)
	);

	// ----------------------------------------
	// host strobes
	// ----------------------------------------
	rwc_pkg::rwc_bus_t bus;
	rwc_pkg::rwc_wake_cfg_t cfg;
	wire host_write;
	wire host_read;

	assign bus = '{chip_select_low: CHIP_SELECT_LOW, write_strobe_low: WRITE_STROBE_LOW,
		read_strobe_low: READ_STROBE_LOW};
	// R11 - both low is a write
	assign host_write = !bus.chip_select_low && !bus.write_strobe_low;
	assign host_read = !bus.chip_select_low && !bus.read_strobe_low;

	// ----------------------------------------
	// power state
	// ----------------------------------------
	rwc_pkg::rwc_pwr_t pwr;
	rwc_pkg::rwc_pwr_t next_pwr;
	wire waking;

	// R07 - in this decode only a write leaves sleep
	// R08 - any write wakes
	assign waking = (pwr == rwc_pkg::RWC_SLEEP) && host_write;
	// R06 - wake event not in this decode
	assign next_pwr = waking ? rwc_pkg::RWC_RUN :
		(pwr == rwc_pkg::RWC_RUN && SLEEP_REQ) ? rwc_pkg::RWC_SLEEP : pwr;

	// R01 - all state cleared by reset
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pwr <= rwc_pkg::RWC_RUN;
		end else if (soft_rst) begin
			pwr <= rwc_pkg::RWC_RUN;
		end else begin
			pwr <= next_pwr;
		end
	end

	// ----------------------------------------
	// write gate
	// ----------------------------------------
	// the wake write itself is swallowed, which is why a read must come first
	logic read_seen;
	wire next_read_seen;

	// R03 - writes need a prior read
	assign next_read_seen = waking ? 1'b0 : (read_seen || host_read);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			read_seen <= 1'b0;
		end else if (soft_rst) begin
			read_seen <= 1'b0;
		end else begin
			read_seen <= next_read_seen;
		end
	end

	// ----------------------------------------
	// wake indicator
	// ----------------------------------------
	logic wake_flag;
	wire next_wake_flag;
	wire wake_level;

	assign cfg = '{enable: WAKE_EN, active_high: WAKE_ACTIVE_HIGH,
		open_drain: WAKE_OPEN_DRAIN};
	// R04 - event sets flag, set beats wake clear
	assign next_wake_flag = cfg.enable &&
		((WAKE_EVENT && pwr == rwc_pkg::RWC_SLEEP) || (wake_flag && !waking));
	// R05 - polarity select; a pending soft reset forces the idle level
	assign wake_level = (next_wake_flag && !soft_rst) ~^ cfg.active_high;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			wake_flag <= 1'b0;
		end else if (soft_rst) begin
			wake_flag <= 1'b0;
		end else begin
			wake_flag <= next_wake_flag;
		end
	end

	// ----------------------------------------
	// reference clock enable
	// ----------------------------------------
	logic [rwc_pkg::REF_DIV_W-1:0] ref_cnt;
	wire ref_wrap;

	// R10 - 25 MHz enable
	assign ref_wrap = ref_cnt == rwc_pkg::REF_DIV_LAST;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt <= '0;
		end else begin
			ref_cnt <= ref_wrap ? '0 : ref_cnt + 1'b1;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			soft_rst <= 1'b0;
			WAKE_INDICATOR_OUT <= !rwc_pkg::WAKE_POL_RST;
			WAKE_INDICATOR_OE <= 1'b1;
			ASLEEP <= 1'b0;
			WRITE_ALLOWED <= 1'b0;
			WRITE_ACCEPT <= 1'b0;
			REF_CLOCK_EN <= 1'b0;
			SOFT_RESET_N <= 1'b0;
		end else begin
			// R02 - software reset path
			soft_rst <= SOFTWARE_RESET_BIT;
			WAKE_INDICATOR_OUT <= cfg.open_drain ? 1'b0 : wake_level;
			// R05 - open drain drives only the low level, the pull-up gives high
			WAKE_INDICATOR_OE <= !cfg.open_drain || !wake_level;
			ASLEEP <= next_pwr == rwc_pkg::RWC_SLEEP && !soft_rst;
			WRITE_ALLOWED <= next_read_seen && !soft_rst && !SOFTWARE_RESET_BIT;
			// R03 - accepted only after read
			WRITE_ACCEPT <= host_write && read_seen && pwr == rwc_pkg::RWC_RUN && !soft_rst;
			REF_CLOCK_EN <= ref_wrap;
			SOFT_RESET_N <= !SOFTWARE_RESET_BIT;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_sleep_write;
		pwr == rwc_pkg::RWC_SLEEP && host_write && !soft_rst;
	endsequence

	// R10 - helper: cycles since the last enable pulse
	// a counter, since a long repetition would be unrolled by the tools
	logic [rwc_pkg::REF_DIV_W-1:0] ref_gap;
	logic ref_seen;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ref_gap <= '0;
			ref_seen <= 1'b0;
		end else begin
			ref_gap <= REF_CLOCK_EN ? '0 : ref_gap + 1'b1;
			ref_seen <= ref_seen || REF_CLOCK_EN;
		end
	end

	wake_by_write_a: assert property (@(posedge CLK) disable iff (!rst_n) // R08
		s_sleep_write |=> pwr == rwc_pkg::RWC_RUN ##1 !ASLEEP)
		else $error("write in sleep did not wake");
	event_no_wake_a: assert property (@(posedge CLK) disable iff (!rst_n) // R06
		pwr == rwc_pkg::RWC_SLEEP && !host_write && !soft_rst |=> pwr == rwc_pkg::RWC_SLEEP)
		else $error("sleep left without a host write");
	leave_only_write_a: assert property (@(posedge CLK) disable iff (!rst_n) // R07
		$fell(pwr == rwc_pkg::RWC_SLEEP) |-> $past(host_write) || $past(soft_rst))
		else $error("sleep ended with no write");
	write_gate_a: assert property (@(posedge CLK) disable iff (!rst_n) // R03
		WRITE_ACCEPT |-> $past(read_seen))
		else $error("write accepted before a read");
	wake_clears_read_a: assert property (@(posedge CLK) disable iff (!rst_n) // R03
		s_sleep_write |=> !read_seen)
		else $error("read gate not rearmed on wake");
	wake_assert_a: assert property (@(posedge CLK) disable iff (!rst_n) // R04
		cfg.enable && WAKE_EVENT && pwr == rwc_pkg::RWC_SLEEP && !soft_rst |=> wake_flag)
		else $error("wake event not flagged");
	wake_polarity_a: assert property (@(posedge CLK) disable iff (!rst_n) // R05
		$past(rst_n) && !$past(cfg.open_drain) |->
		WAKE_INDICATOR_OUT == (wake_flag ~^ $past(cfg.active_high)))
		else $error("wake output level wrong");
	open_drain_a: assert property (@(posedge CLK) disable iff (!rst_n) // R05
		$past(cfg.open_drain) |-> !WAKE_INDICATOR_OUT)
		else $error("open drain drove high");
	ref_period_a: assert property (@(posedge CLK) disable iff (!rst_n) // R10
		REF_CLOCK_EN |-> ##10 REF_CLOCK_EN)
		else $error("reference enable missing after a period");
	ref_gap_a: assert property (@(posedge CLK) disable iff (!rst_n) // R10
		ref_seen |-> ref_gap <= rwc_pkg::REF_DIV_LAST &&
		(!REF_CLOCK_EN || ref_gap == rwc_pkg::REF_DIV_LAST))
		else $error("reference enable gap wrong");
	reset_state_a: assert property (@(posedge CLK) $rose(rst_n) |-> // R01
		!read_seen && !wake_flag && pwr == rwc_pkg::RWC_RUN)
		else $error("state not cleared by reset");
endmodule // rwc_top

// ==== src/rwc_pkg.sv ====
// package for the reset and wake control block
// assumes one 250 MHz core clock and an active-low asynchronous reset pin
package rwc_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int REF_MHZ = 25;
	// core cycles per reference clock period
	localparam int REF_DIV = CLK_MHZ / REF_MHZ;
	localparam int REF_DIV_W = 4;
	localparam logic [REF_DIV_W-1:0] REF_DIV_LAST = 4'(REF_DIV - 1);
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic WAKE_POL_RST = 1'b1;
	localparam logic WAKE_OD_RST = 1'b0;
	localparam logic WAKE_EN_RST = 1'b0;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		RWC_RUN,
		RWC_SLEEP
	} rwc_pwr_t;

	typedef struct packed {
		logic chip_select_low;
		logic write_strobe_low;
		logic read_strobe_low;
	} rwc_bus_t;

	typedef struct packed {
		logic enable;
		logic active_high;
		logic open_drain;
	} rwc_wake_cfg_t;
endpackage

// ==== src/rwc_rst_sync.sv ====
// reset release synchroniser
// assumes the reset pin may fall at any time relative to CLK
`timescale 1ns/1ps
module rwc_rst_sync #(
	parameter int STAGES = rwc_pkg::SYNC_STAGES
) (
	input wire logic CLK,
	input wire logic ARST_N,
	output logic rst_n
);
	logic [STAGES-1:0] chain;

	// R12 - assert now, release clocked
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			chain <= '0;
		end else begin
			chain <= {chain[STAGES-2:0], 1'b1};
		end
	end

	assign rst_n = chain[STAGES-1];

	// R12 - release takes stages
	rst_release_a: assert property (@(posedge CLK) $rose(ARST_N) |-> !rst_n) // R12
		else $error("internal reset released without synchroniser delay");
endmodule // rwc_rst_sync

// ==== tb/rwc_host_model.sv ====
// host model: drives the block's chip select and strobes
// assumes the block samples them on the rising edge of CLK
`timescale 1ns/1ps
module rwc_host_model (
	input wire logic CLK,
	output rwc_pkg::rwc_bus_t BUS
);
	initial BUS = 3'h7;
	// strobes low
	// one cycle, held a full clock; no address is modelled,
	// so every write stands for the byte-order test write
	task automatic cyc(input logic [2:0] v);
		@(posedge CLK);
		BUS <= v;
		@(posedge CLK);
		BUS <= 3'h7;
		#1;
	endtask
endmodule // rwc_host_model

// ==== tb/rwc_top_tb.sv ====
// testbench for the reset and wake block
// assumes the host model on the bus side; bus values are cs,wr,rd
`timescale 1ns/1ps
module rwc_top_tb;
	logic clk, arst_n, software_reset_bit, sleep_req, wake_event;
	rwc_pkg::rwc_wake_cfg_t cfg;
	rwc_pkg::rwc_bus_t bus;
	wire cs_low, wr_low, rd_low, wake_en, wake_hi, wake_od;
	assign {cs_low, wr_low, rd_low} = bus;
	assign {wake_en, wake_hi, wake_od} = cfg;
	logic w_out, w_oe, asleep, allowed, accept, ref_en, soft_n;
	int errors = 0, checks_done = 0, cyc_n = 0;
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	rwc_host_model u_host (.CLK(clk), .BUS(bus));
	rwc_top u_dut (.CLK(clk), .ARST_N(arst_n), .SOFTWARE_RESET_BIT(software_reset_bit),
		.CHIP_SELECT_LOW(cs_low), .WRITE_STROBE_LOW(wr_low),
		.READ_STROBE_LOW(rd_low), .SLEEP_REQ(sleep_req),
		.WAKE_EVENT(wake_event), .WAKE_EN(wake_en), .WAKE_ACTIVE_HIGH(wake_hi),
		.WAKE_OPEN_DRAIN(wake_od), .WAKE_INDICATOR_OUT(w_out),
		.WAKE_INDICATOR_OE(w_oe), .ASLEEP(asleep), .WRITE_ALLOWED(allowed),
		.WRITE_ACCEPT(accept), .REF_CLOCK_EN(ref_en), .SOFT_RESET_N(soft_n));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic go_sleep;
		@(posedge clk);
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		#1;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_gate;
		chk("allowed", 1'b0, allowed);
		u_host.cyc(3'h1);
		chk("accept", 1'b0, accept);
		u_host.cyc(3'h2);
		chk("allowed", 1'b1, allowed);
		u_host.cyc(3'h1);
		chk("accept", 1'b1, accept);
		u_host.cyc(3'h1);
		chk("accept", 1'b1, accept);
		$display("test gate done");
	endtask
	task automatic t_sleep;
		go_sleep;
		chk("asleep", 1'b1, asleep);
		u_host.cyc(3'h2);
		chk("asleep", 1'b1, asleep);
		u_host.cyc(3'h5);
		chk("asleep", 1'b1, asleep);
		u_host.cyc(3'h1);
		chk("asleep", 1'b0, asleep);
		chk("accept", 1'b0, accept);
		chk("allowed", 1'b0, allowed);
		u_host.cyc(3'h2);
		u_host.cyc(3'h1);
		chk("accept", 1'b1, accept);
		$display("test sleep done");
	endtask
	// last pass has the indicator disabled: no assertion expected
	task automatic t_wake;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			cfg <= '{enable: i < 4, active_high: i[0], open_drain: i[1]};
			go_sleep;
			@(posedge clk);
			wake_event <= 1'b1;
			@(posedge clk);
			wake_event <= 1'b0;
			#1;
			chk("oe", i[1] ? i[0] ^ (i < 4) : 1'b1, w_oe);
			chk("out", i[1] ? 1'b0 : i[0] ~^ (i < 4), w_out);
			tick(2);
			chk("asleep", 1'b1, asleep);
			u_host.cyc(3'h1);
			tick(1);
			chk("oe idle", !i[1] || i[0], w_oe);
			chk("out idle", i[1] ? 1'b0 : ~i[0], w_out);
		end
		$display("test wake done");
	endtask
	task automatic t_soft;
		u_host.cyc(3'h2);
		chk("allowed", 1'b1, allowed);
		@(posedge clk);
		software_reset_bit <= 1'b1;
		@(posedge clk);
		software_reset_bit <= 1'b0;
		#1;
		chk("soft_n", 1'b0, soft_n);
		tick(2);
		chk("allowed", 1'b0, allowed);
		chk("soft_n", 1'b1, soft_n);
		$display("test soft reset done");
	endtask
	task automatic t_ref;
		int n = 0;
		int last = -1;
		int bad = 0;
		for (int c = 0; c < 100; c++) begin
			tick(1);
			if (ref_en === 1'b1) begin
				if (last >= 0 && c - last != rwc_pkg::REF_DIV)
					bad++;
				last = c;
				n++;
			end
		end
		chk("ref count", 1'b1, n == 100 / rwc_pkg::REF_DIV);
		chk("ref gap", 1'b1, bad == 0);
		$display("test ref clock done");
	endtask
	// reset dropped between edges must act before the next edge
	task automatic t_async;
		u_host.cyc(3'h2);
		go_sleep;
		arst_n = 1'b0;
		#0.5;
		chk("asleep", 1'b0, asleep);
		chk("allowed", 1'b0, allowed);
		chk("oe", 1'b1, w_oe);
		@(posedge clk);
		arst_n <= 1'b1;
		tick(3);
		chk("asleep", 1'b0, asleep);
		$display("test async reset done");
	endtask
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			errors++;
			finish_test;
		end
	end
	initial begin
		arst_n = 1'b0;
		software_reset_bit = 1'b0;
		sleep_req = 1'b0;
		wake_event = 1'b0;
		cfg = '0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		tick(3);
		t_gate;
		t_sleep;
		t_wake;
		t_soft;
		t_ref;
		t_async;
		finish_test;
	end
endmodule // rwc_top_tb
